//--- design/adcst_regs.vh
// register offsets, field positions, reset values and source codes for the converter control
`ifndef ADCST_REGS_VH
`define ADCST_REGS_VH
`define ADCST_OFF_COMMAND   12'h000
`define ADCST_OFF_RESULT    12'h004
`define ADCST_OFF_TIME      12'h008
`define ADCST_OFF_TEST      12'h00c
`define ADCST_OFF_STATUS    12'h010
`define ADCST_OFF_MASK      12'h014
`define ADCST_OFF_CC_CTRL   12'h018
`define ADCST_CMD_CH_LSB    0
`define ADCST_CMD_CH_MSB    2
`define ADCST_CMD_GO_BIT    3
`define ADCST_CMD_MODE_LSB  4
`define ADCST_CMD_MODE_MSB  5
`define ADCST_MODE_10BIT    2'h0
`define ADCST_MODE_8BIT     2'h1
`define ADCST_MODE_THR_HIGH 2'h2
`define ADCST_MODE_THR_LOW  2'h3
`define ADCST_TEST_SRC_LSB  0
`define ADCST_TEST_SRC_MSB  1
`define ADCST_TEST_OFS_LSB  2
`define ADCST_TEST_OFS_MSB  3
`define ADCST_SRC_PIN       2'h0
`define ADCST_SRC_GROUND    2'h1
`define ADCST_SRC_REF       2'h2
`define ADCST_TIME_CONV_LSB 0
`define ADCST_TIME_CONV_MSB 4
`define ADCST_TIME_SAMP_LSB 5
`define ADCST_TIME_SAMP_MSB 7
`define ADCST_CC_START_BIT  2
`define ADCST_STAT_DONE_BIT 0
`define ADCST_RST_COMMAND   8'h00
`define ADCST_RST_TIME      8'hff
`define ADCST_RST_TEST      8'h00
`define ADCST_RST_MASK      1'h0
`define ADCST_RST_CC_CTRL   4'h0
`define ADCST_FULL_SCALE    10'h3ff
`define ADCST_REF_CODE      10'h3ff
`define ADCST_GND_CODE      10'h000
`define ADCST_OFS_STEP      10'h001
`endif

//--- design/adcst_timer.v
// phase timer: counts sample then conversion time from the timing register
`timescale 1ns/1ns
module adcst_timer
(
    input  wire       CLK,
    input  wire       RESET,
    input  wire       start,
    input  wire [2:0] samp_time,
    input  wire [4:0] conv_time,
    output reg        sampling,
    output reg        latch,
    output reg        done
);
    reg [5:0] count;
    reg       busy;
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            count    <= 6'h00;
            busy     <= 1'b0;
            sampling <= 1'b0;
            latch    <= 1'b0;
            done     <= 1'b0;
        end
        else
        begin
            latch <= 1'b0;
            done  <= 1'b0;
            if (start && !busy)
            begin
                // sample phase lasts samp_time+1 cycles, conversion conv_time+1 cycles
                busy     <= 1'b1;
                sampling <= 1'b1;
                count    <= {3'h0, samp_time};
            end
            else if (busy)
            begin
                if (count != 6'h00)
                    count <= count - 6'h01;
                else if (sampling)
                begin
                    sampling <= 1'b0;
                    latch    <= 1'b1;
                    count    <= {1'b0, conv_time};
                end
                else
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

//--- design/adcst_top.v
// converter control: apb registers, start logic, sequencing, threshold detect, interrupt
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "adcst_regs.vh"
module adcst_top
(
    input  wire        CLK,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire [79:0] ANALOG_CODE,
    input  wire [3:0]  COMPARE_EVENT,
    output reg  [2:0]  CHANNEL_SELECT,
    output reg         SAMPLE_ACTIVE,
    output reg         BUSY,
    output reg         IRQ
);
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [7:0]  command;
    reg  [9:0]  result;
    reg  [7:0]  timing;
    reg  [7:0]  offset_test;
    reg         status_done;
    reg         mask_done;
    reg  [3:0]  capture_compare_control_reg;
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [9:0]  held_code;
    reg         thr_above;
    reg         thr_valid;
    reg         timer_start;
    reg  [31:0] read_mux;
    reg         hit_map;
    reg  [9:0]  pin_code;
    reg  [9:0]  source_code;
    reg  [10:0] trimmed;

    wire        sampling;
    wire        latch;
    wire        conv_done;
    wire        access   = PSEL && PENABLE && PREADY;
    wire        wr       = access && PWRITE;
    wire [2:0]  channel  = command[`ADCST_CMD_CH_MSB:`ADCST_CMD_CH_LSB];
    wire [1:0]  mode     = command[`ADCST_CMD_MODE_MSB:`ADCST_CMD_MODE_LSB];
    wire [1:0]  source   = offset_test[`ADCST_TEST_SRC_MSB:`ADCST_TEST_SRC_LSB];
    wire [1:0]  ofs_trim = offset_test[`ADCST_TEST_OFS_MSB:`ADCST_TEST_OFS_LSB];
    wire        thr_mode = mode[1];
    wire        wr_cmd   = wr && (PADDR == `ADCST_OFF_COMMAND);
    wire        wr_res   = wr && (PADDR == `ADCST_OFF_RESULT);
    wire        cc_fire  = |(COMPARE_EVENT & capture_compare_control_reg);
    wire        go_now   = wr_cmd && PWDATA[`ADCST_CMD_GO_BIT];
    wire        trigger  = go_now || cc_fire;
    wire [9:0]  thr_ref  = {result[9:2], 2'h0};
    wire        above    = held_code >= thr_ref;
    wire        crossed  = thr_valid && (above != thr_above) &&
                           ((mode == `ADCST_MODE_THR_HIGH) ? above : !above);
    wire        event_set;
    wire [89:0] mux_chain;

    // channel mux; ANALOG_CODE packs eight 10-bit codes, channel 0 lowest
    // an or-chain of per-channel gates, so only the selected code survives
    assign mux_chain[9:0] = 10'h000;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_chan
            wire sel = (channel == g);
            assign mux_chain[10*g+19:10*g+10] = mux_chain[10*g+9:10*g] |
                                                (sel ? ANALOG_CODE[10*g+9:10*g] : 10'h000);
        end
    endgenerate

    always @*
    begin
        pin_code = mux_chain[89:80];
    end

    // ground or reference replaces the pin, then the offset trim is added, saturating at full scale
    always @*
    begin
        case (source)
            `ADCST_SRC_GROUND: source_code = `ADCST_GND_CODE;
            `ADCST_SRC_REF:    source_code = `ADCST_REF_CODE;
            default:           source_code = pin_code;
        endcase
        trimmed = {1'b0, source_code} + {9'h000, ofs_trim};
        if (trimmed[10])
            trimmed = {1'b0, `ADCST_FULL_SCALE};
    end

    adcst_timer u_timer
    (
        .CLK       (CLK),
        .RESET     (RESET),
        .start     (timer_start),
        .samp_time (timing[`ADCST_TIME_SAMP_MSB:`ADCST_TIME_SAMP_LSB]),
        .conv_time (timing[`ADCST_TIME_CONV_MSB:`ADCST_TIME_CONV_LSB]),
        .sampling  (sampling),
        .latch     (latch),
        .done      (conv_done)
    );

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE: if (trigger) next_state = ST_RUN;
            ST_RUN:  if (conv_done) next_state = ST_DONE;
            ST_DONE:
            begin
                // threshold modes keep converting until the crossing is seen
                if (thr_mode && !crossed)
                    next_state = ST_RUN;
                else
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    assign event_set = (state == ST_DONE) && (!thr_mode || crossed);

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            state       <= ST_IDLE;
            held_code   <= 10'h000;
            thr_above   <= 1'b0;
            thr_valid   <= 1'b0;
            timer_start <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            timer_start <= (next_state == ST_RUN) && (state != ST_RUN);
            if (latch)
                held_code <= trimmed[9:0];
            if (state == ST_DONE && thr_mode)
            begin
                thr_above <= above;
                thr_valid <= !crossed;
            end
            if (trigger && state == ST_IDLE)
                thr_valid <= 1'b0;
        end
    end

    // register file
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            command                     <= `ADCST_RST_COMMAND;
            result                      <= 10'h000;
            timing                      <= `ADCST_RST_TIME;
            offset_test                 <= `ADCST_RST_TEST;
            status_done                 <= 1'b0;
            mask_done                   <= `ADCST_RST_MASK;
            capture_compare_control_reg <= `ADCST_RST_CC_CTRL;
        end
        else
        begin
            if (wr_cmd)
                command <= PWDATA[7:0];
            if (wr_res)
                result[9:2] <= PWDATA[15:8];
            else if (state == ST_DONE && !thr_mode)
            begin
                if (mode == `ADCST_MODE_8BIT)
                    result <= {held_code[9:2], 2'h0};
                else
                    result <= held_code;
            end
            if (wr && PADDR == `ADCST_OFF_TIME)
                timing <= PWDATA[7:0];
            if (wr && PADDR == `ADCST_OFF_TEST)
                offset_test <= PWDATA[7:0];
            if (wr && PADDR == `ADCST_OFF_MASK)
                mask_done <= PWDATA[`ADCST_STAT_DONE_BIT];
            if (wr && PADDR == `ADCST_OFF_CC_CTRL)
                capture_compare_control_reg <= {4{PWDATA[`ADCST_CC_START_BIT]}} &
                                               PWDATA[7:4];
            // set wins over the write-one-to-clear
            if (event_set)
                status_done <= 1'b1;
            else if (wr && PADDR == `ADCST_OFF_STATUS && PWDATA[`ADCST_STAT_DONE_BIT])
                status_done <= 1'b0;
        end
    end

    always @*
    begin
        hit_map  = 1'b1;
        read_mux = 32'h00000000;
        case (PADDR)
            `ADCST_OFF_COMMAND: read_mux = {24'h000000, command};
            `ADCST_OFF_RESULT:  read_mux = {16'h0000, result[9:2], result[1:0], 5'h00,
                                            BUSY};
            `ADCST_OFF_TIME:    read_mux = {24'h000000, timing};
            `ADCST_OFF_TEST:    read_mux = {24'h000000, offset_test};
            `ADCST_OFF_STATUS:  read_mux = {31'h00000000, status_done};
            `ADCST_OFF_MASK:    read_mux = {31'h00000000, mask_done};
            `ADCST_OFF_CC_CTRL: read_mux = {24'h000000, capture_compare_control_reg,
                                            1'b0, |capture_compare_control_reg, 2'h0};
            default:            hit_map  = 1'b0;
        endcase
    end

    // apb slave: one wait state keeps every output registered
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            PRDATA         <= 32'h00000000;
            PREADY         <= 1'b0;
            PSLVERR        <= 1'b0;
            CHANNEL_SELECT <= 3'h0;
            SAMPLE_ACTIVE  <= 1'b0;
            BUSY           <= 1'b0;
            IRQ            <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !hit_map;
            if (PSEL && PENABLE && !PREADY && !PWRITE)
                PRDATA <= read_mux;
            CHANNEL_SELECT <= channel;
            SAMPLE_ACTIVE  <= sampling;
            BUSY           <= (next_state != ST_IDLE);
            IRQ            <= (status_done || event_set) && mask_done;
        end
    end
endmodule

//--- bench/adcst_asserts.sv
// port checker for the converter control
`timescale 1ns/1ns
`include "adcst_regs.vh"
module adcst_asserts
(
    input logic        CLK,
    input logic        RESET,
    input logic        PSEL,
    input logic        PENABLE,
    input logic        PWRITE,
    input logic [11:0] PADDR,
    input logic [31:0] PWDATA,
    input logic        PREADY,
    input logic        PSLVERR,
    input logic [2:0]  CHANNEL_SELECT,
    input logic        SAMPLE_ACTIVE,
    input logic        BUSY,
    input logic        IRQ
);
    logic [2:0] last_ch;
    wire        cmd_wr = PREADY && PWRITE && PADDR == `ADCST_OFF_COMMAND;
    // status and mask share one 8-byte slot
    wire        irq_wr = PREADY && PWRITE && PADDR[11:3] == 9'h002;
    wire        bad_ad = PADDR[1:0] != 2'h0 || PADDR > `ADCST_OFF_CC_CTRL;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    always_ff @(posedge CLK)
        if (RESET)
            last_ch <= 3'h0;
        else if (cmd_wr)
            last_ch <= PWDATA[2:0];
    sequence s_access;
        PSEL && PENABLE && !$past(PENABLE);
    endsequence
    sequence s_go;
        cmd_wr && PWDATA[`ADCST_CMD_GO_BIT] && !BUSY;
    endsequence
    a_ready_timing: assert property (s_access |=> PREADY) else $error("late ready");
    a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("long ready");
    a_error_map: assert property (PREADY |-> PSLVERR == bad_ad) else $error("bad slverr");
    a_chan_select: assert property ($stable(last_ch) [*2] |-> CHANNEL_SELECT == last_ch)
        else $error("bad channel");
    a_start_now: assert property (s_go |-> ##[1:3] BUSY) else $error("no start");
    a_sample_busy: assert property (SAMPLE_ACTIVE |-> BUSY) else $error("idle sample");
    a_conv_after: assert property ($fell(SAMPLE_ACTIVE) |-> BUSY) else $error("no conv");
    a_irq_clear: assert property ($fell(IRQ) |-> $past(irq_wr) || $past(irq_wr, 2))
        else $error("irq lost");
    a_irq_raise: assert property ($rose(IRQ) |-> $past(BUSY) || $past(irq_wr)
        || $past(irq_wr, 2)) else $error("irq early");
endmodule
bind adcst_top adcst_asserts u_chk (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PREADY, .PSLVERR, .CHANNEL_SELECT, .SAMPLE_ACTIVE, .BUSY, .IRQ);

//--- bench/adcst_front.sv
// analog inputs and compare event source facing the converter control
`timescale 1ns/1ns
module adcst_front
(
    input  logic        clk,
    input  logic [9:0]  level,
    input  logic [3:0]  fire,
    output logic [79:0] analog_code,
    output logic [3:0]  compare_event
);
    // channels sit 8 codes apart so a wrong mux shows
    always_comb
        for (int n = 0; n < 8; n++)
            analog_code[10*n +: 10] = level + 10'(8 * n);
    initial
        compare_event = 4'h0;
    // one-cycle pulses launched after an edge
    always @(posedge clk)
        compare_event <= fire;
endmodule

//--- bench/tb.sv
// self-checking bench for the converter control
`timescale 1ns/1ns
`include "adcst_regs.vh"
module tb;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic        sample_active, busy, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [79:0] analog_code;
    logic [3:0]  compare_event, fire;
    logic [9:0]  level;
    logic [2:0]  channel_select;
    int          fails, samples_checked, samp;
    logic [11:0] regs[6] = '{`ADCST_OFF_COMMAND, `ADCST_OFF_TIME, `ADCST_OFF_TEST,
        `ADCST_OFF_STATUS, `ADCST_OFF_MASK, `ADCST_OFF_CC_CTRL};
    logic [31:0] rst[6] = '{`ADCST_RST_COMMAND, `ADCST_RST_TIME, `ADCST_RST_TEST, 0,
        `ADCST_RST_MASK, `ADCST_RST_CC_CTRL};
    // ground, reference, ground plus two steps, reference saturating
    logic [3:0]  tsel[4] = '{4'h1, 4'h2, 4'h9, 4'h6};
    logic [9:0]  tcode[4] = '{`ADCST_GND_CODE, `ADCST_REF_CODE, 10'h002, `ADCST_REF_CODE};
    adcst_top i_dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ANALOG_CODE(analog_code), .COMPARE_EVENT(compare_event),
        .CHANNEL_SELECT(channel_select), .SAMPLE_ACTIVE(sample_active), .BUSY(busy), .IRQ(irq));
    adcst_front i_front (.clk(clk), .level(level), .fire(fire), .analog_code(analog_code),
        .compare_event(compare_event));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic summarize();
        $display("%0d checks, %0d mismatches", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        check(1'b0, 1'b1);
        summarize();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
            @(posedge clk);
        while (pready !== 1'b1 && ++n < 20);
        if (n == 20)
            hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // counts sample cycles until the sequencer goes idle again
    task automatic run(input logic want);
        int   n;
        logic seen;
        seen = 1'b0;
        samp = 0;
        for (n = 0; n < 3000 && !(seen && busy === 1'b0) && (want || n < 20); n++)
        begin
            @(posedge clk);
            samp += sample_active === 1'b1;
            seen |= busy === 1'b1;
        end
        if (n == 3000)
            hang();
        check(seen, want);
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, fire} = '0;
        level = 10'h103;
        reset = 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        foreach (regs[i])
        begin
            apb(1'b0, regs[i], 0);
            check(rd, rst[i]);
        end
        apb(1'b1, 12'h01c, 32'hff);
        apb(1'b0, 12'h01c, 0);
        check(rd, 0);
        check(err, 1'b1);
        $display("test registers end");
        apb(1'b1, `ADCST_OFF_COMMAND, 32'h0c);
        run(1'b1);
        check(samp, 8);
        check(channel_select, 3'h4);
        apb(1'b0, `ADCST_OFF_RESULT, 0);
        check(rd[15:6], level + 10'h020);
        apb(1'b0, `ADCST_OFF_STATUS, 0);
        check(rd[0], 1'b1);
        check(irq, 1'b0);
        apb(1'b1, `ADCST_OFF_MASK, 1);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        apb(1'b1, `ADCST_OFF_STATUS, 1);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        apb(1'b1, `ADCST_OFF_TIME, 32'h41);
        apb(1'b1, `ADCST_OFF_COMMAND, 32'h1a);
        run(1'b1);
        check(samp, 3);
        apb(1'b0, `ADCST_OFF_RESULT, 0);
        check(rd[15:6], (level + 10'h010) & 10'h3fc);
        $display("test conversion end");
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `ADCST_OFF_TEST, tsel[i]);
            apb(1'b1, `ADCST_OFF_COMMAND, 32'h08);
            run(1'b1);
            apb(1'b0, `ADCST_OFF_RESULT, 0);
            check(rd[15:6], tcode[i]);
        end
        apb(1'b1, `ADCST_OFF_TEST, 0);
        $display("test offset end");
        apb(1'b1, `ADCST_OFF_COMMAND, 32'h03);
        apb(1'b1, `ADCST_OFF_CC_CTRL, 32'h14);
        apb(1'b0, `ADCST_OFF_CC_CTRL, 0);
        check(rd[7:0], 8'h14);
        // a module without start enable must not trigger
        for (int i = 1; i >= 0; i--)
        begin
            fire <= 4'h1 << i;
            @(posedge clk);
            fire <= 4'h0;
            run(i == 0);
        end
        apb(1'b0, `ADCST_OFF_RESULT, 0);
        check(rd[15:6], level + 10'h018);
        $display("test compare end");
        apb(1'b1, `ADCST_OFF_RESULT, 32'h8000);
        for (int m = 2; m < 4; m++)
        begin
            apb(1'b1, `ADCST_OFF_STATUS, 1);
            level <= m == 2 ? 10'h100 : 10'h300;
            apb(1'b1, `ADCST_OFF_COMMAND, 32'h08 | m << 4);
            repeat (40) @(posedge clk);
            apb(1'b0, `ADCST_OFF_STATUS, 0);
            check({busy, rd[0]}, 2'b10);
            level <= m == 2 ? 10'h300 : 10'h100;
            run(1'b1);
            apb(1'b0, `ADCST_OFF_STATUS, 0);
            check({irq, rd[0]}, 2'b11);
        end
        $display("test threshold end");
        summarize();
    end
endmodule
